/* File: chai_pkg.sv */
// constants and carrier types of the host access front end
// ****************************************************************************
// Overview of operation
// R1 - select A low gives multiplexed parallel bus
// R2 - select A high, B low gives serial slave
// R3 - all transfers are bytes, wide registers paged
// R4 - target address is page joined with byte
// R5 - parallel pages hold 256 bytes
// R6 - serial address MSB is direction, 128-byte pages
// R7 - serial incremental mode steps the address
// R8 - ready output shows next access may start
// R9 - primary irq always, secondary clock or irq
// R10 - serial mode turns spare pins into I/O
// R11 - each spare pin may carry an interrupt
// R12 - input pins may trigger CAN transmission
// R13 - core interrupts routed to chosen pins
// R14 - each port pin gets one role
// R15 - sleep and power-down shown on pins
// R16 - serial channel may boot from EEPROM
// R17 - address strobe latches the address byte
// R18 - port pins form the address/data bus
// R19 - serial ignored while slave select inactive
// R20 - host clocks serial, device returns read data
// R21 - serial access: address byte then data bytes
// R22 - host rewrites page before crossing pages
// ****************************************************************************
package chai_pkg;
  localparam int          DATA_W        = 8;
  localparam int          PAGE_W        = 8;
  localparam int          ADDR_W        = PAGE_W + DATA_W;
  localparam int          SER_DIR_BIT   = 7;
  localparam logic [7:0]  SER_ADDR_MASK = 8'h7F;
  localparam logic [7:0]  PAGE_REG_OFFS = 8'h7F;
  localparam logic [7:0]  IO_REG_OFFS   = 8'h7E;
  localparam logic [7:0]  PAGE_RST      = 8'h00;
  localparam logic [7:0]  IO_RST        = 8'h00;
  localparam logic [1:0]  ROLE_COMM     = 2'h0;
  localparam logic [1:0]  ROLE_MON      = 2'h1;
  localparam logic [1:0]  ROLE_IRQ      = 2'h2;
  localparam logic [1:0]  ROLE_GPIO     = 2'h3;
  localparam int          CLKOUT_DIV    = 4;

  typedef enum logic [1:0] {ST_IDLE, ST_CORE, ST_DONE} chai_state_type;

  // one pending register access
  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] data;
    logic              isRead;
  } chai_req_type;
endpackage : chai_pkg

/* File: chai_host_access.sv */
// host access front end: parallel bus, serial slave, port and interrupt pins
`timescale 1ns/10ps
module chai_host_access
  import chai_pkg::*;
#(
  parameter int IRQ_W = 4
)
(
  input  wire logic              ref_clk,
  input  wire logic              rst_n,
  input  wire logic              ifaceSelectA,
  input  wire logic              ifaceSelectB,
  input  wire logic              csN,
  input  wire logic              aleOrStrobe,
  input  wire logic              wrOrRwN,
  input  wire logic              rdOrEnable,
  input  wire logic [7:0]        portIn,
  output logic      [7:0]        portOut,
  output logic      [7:0]        portOe,
  input  wire logic              serialClk,
  input  wire logic              slaveSelectLineN,
  input  wire logic              hostToDeviceData,
  output logic                   deviceToHostData,
  output logic                   readyOut,
  output logic                   primaryIrqLine,
  output logic                   clkoutOrIrqLine,
  output logic                   sleepStateOut,
  output logic                   powerDownStateOut,
  output logic                   eepromBootMode,
  output logic      [7:0]        txTrigger,
  input  wire logic              incrementEn,
  input  wire logic              clkoutSel,
  input  wire logic [IRQ_W-1:0]  primaryIrqMask,
  input  wire logic [IRQ_W-1:0]  secondaryIrqMask,
  input  wire logic [15:0]       pinRole,
  input  wire logic [7:0]        gpioDir,
  input  wire logic [7:0]        txTrigEn,
  input  wire logic [IRQ_W-1:0]  coreIrq,
  input  wire logic [1:0]        canActivity,
  input  wire logic              coreSleep,
  input  wire logic              corePowerDown,
  output logic                   coreReq,
  output chai_req_type           coreCmd,
  input  wire logic              coreAck,
  input  wire logic [7:0]        coreRdata
);

  if (IRQ_W < 1 || IRQ_W > 8)
  begin : gIrqCheck
    $error("IRQ_W must lie between 1 and 8");
  end

  // ************************************************************************
  // serial link domain
  // ************************************************************************
  logic [2:0] bitCnt_q;
  logic [6:0] shiftIn_q;
  logic [7:0] byteOut_q, misoSh_q, rdData_q;
  logic       gotAddr_q, byteFirst_q, byteTgl_q;

  // sample host data on the falling edge; frame state cleared while deselected
  always_ff @(negedge serialClk or posedge slaveSelectLineN)
  begin
    if (slaveSelectLineN)
    begin
      bitCnt_q  <= 3'h0;                                 // see R19
      shiftIn_q <= 7'h00;
      gotAddr_q <= 1'b0;
    end
    else
    begin
      bitCnt_q  <= bitCnt_q + 3'h1;
      shiftIn_q <= {shiftIn_q[5:0], hostToDeviceData};   // see R20
      if (bitCnt_q == 3'h7)
      begin
        gotAddr_q <= 1'b1;                               // see R21
      end
    end
  end

  // completed byte and its event toggle survive the frame end
  always_ff @(negedge serialClk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      byteOut_q   <= 8'h00;
      byteFirst_q <= 1'b0;
      byteTgl_q   <= 1'b0;
    end
    else if (!slaveSelectLineN && bitCnt_q == 3'h7)
    begin
      byteOut_q   <= {shiftIn_q, hostToDeviceData};      // see R3
      byteFirst_q <= !gotAddr_q;                         // see R21
      byteTgl_q   <= !byteTgl_q;
    end
  end

  // read data shifts out on the rising edge; stable because host waited on ready
  always_ff @(posedge serialClk or posedge slaveSelectLineN)
  begin
    if (slaveSelectLineN)
    begin
      misoSh_q         <= 8'h00;
      deviceToHostData <= 1'b0;
    end
    else if (bitCnt_q == 3'h0)
    begin
      misoSh_q         <= {rdData_q[6:0], 1'b0};         // see R20
      deviceToHostData <= rdData_q[7];
    end
    else
    begin
      misoSh_q         <= {misoSh_q[6:0], 1'b0};
      deviceToHostData <= misoSh_q[7];
    end
  end

  // ************************************************************************
  // pin synchronisers
  // ************************************************************************
  localparam int SYNC_W = 15;
  logic [SYNC_W-1:0] pinMeta_q;
  logic [SYNC_W-1:0] pinSync_q;
  logic [SYNC_W-1:0] pinPrev_q;
  logic [SYNC_W-1:0] pinRaw;

  assign pinRaw = {byteTgl_q, ifaceSelectA, ifaceSelectB, csN, aleOrStrobe, wrOrRwN, rdOrEnable, portIn};

  // two flops per pin; a third stage keeps the old level so the strobe, toggle and port pins get a real edge detector
  always_ff @(posedge ref_clk)
  begin
    pinMeta_q <= pinRaw;
    pinSync_q <= pinMeta_q;
    pinPrev_q <= pinSync_q;
  end

  logic       tglS, selAS, selBS, csNS, aleS, wrS, rdS;
  logic [7:0] portS, portPrev;
  logic       aleP, wrP, rdP;
  logic       serialMode, motoMode, tglEvt;

  assign {tglS, selAS, selBS, csNS, aleS, wrS, rdS} = pinSync_q[14:8];
  assign portS      = pinSync_q[7:0];
  assign portPrev   = pinPrev_q[7:0];
  assign aleP       = pinPrev_q[10];
  assign wrP        = pinPrev_q[9];
  assign rdP        = pinPrev_q[8];
  assign serialMode = selAS && !selBS;                   // see R2
  assign motoMode   = selBS;                             // see R1
  assign tglEvt     = tglS ^ pinPrev_q[14];

  // ************************************************************************
  // access engine
  // ************************************************************************
  chai_state_type state_q, state_d;
  logic [7:0]     addrLatch_q, addrLatch_d;
  logic [7:0]     page_q, page_d;
  logic [7:0]     ioOut_q, ioOut_d;
  logic [6:0]     serAddr_q, serAddr_d;
  logic           serRead_q, serRead_d;
  logic [7:0]     rdData_d;
  logic           adOe_q, adOe_d;
  chai_req_type   cmd_q, cmd_d;
  logic           newReq;
  chai_req_type   newCmd;

  always_comb
  begin
    addrLatch_d = addrLatch_q;
    serAddr_d   = serAddr_q;
    serRead_d   = serRead_q;
    newReq      = 1'b0;
    newCmd      = '0;
    adOe_d      = 1'b0;
    if (!serialMode && !selAS)
    begin
      if (aleP && !aleS)
      begin
        addrLatch_d = portS;                             // see R17
      end
      if (!motoMode)
      begin
        adOe_d = !csNS && !rdS;                          // see R18
        if (!csNS && !wrP && wrS)
        begin
          newReq = 1'b1;
          newCmd = '{addr: {page_q, addrLatch_q}, data: portPrev, isRead: 1'b0};   // see R5
        end
        else if (!csNS && rdP && !rdS)
        begin
          newReq = 1'b1;
          newCmd = '{addr: {page_q, addrLatch_q}, data: 8'h00, isRead: 1'b1};
        end
      end
      else
      begin
        adOe_d = !csNS && rdS && wrS;
        if (!csNS && rdP && !rdS && !wrS)
        begin
          newReq = 1'b1;
          newCmd = '{addr: {page_q, addrLatch_q}, data: portPrev, isRead: 1'b0};
        end
        else if (!csNS && !rdP && rdS && wrS)
        begin
          newReq = 1'b1;
          newCmd = '{addr: {page_q, addrLatch_q}, data: 8'h00, isRead: 1'b1};
        end
      end
    end
    else if (serialMode && tglEvt)
    begin
      if (byteFirst_q)
      begin
        serAddr_d = byteOut_q[6:0] & SER_ADDR_MASK[6:0]; // see R6
        serRead_d = byteOut_q[SER_DIR_BIT];              // see R21
        newReq    = byteOut_q[SER_DIR_BIT];
        newCmd    = '{addr: {page_q, 1'b0, byteOut_q[6:0]}, data: 8'h00, isRead: 1'b1};
      end
      else
      begin
        serAddr_d = incrementEn ? serAddr_q + 7'h01 : serAddr_q;   // see R7
        newReq    = 1'b1;
        if (serRead_q)
        begin
          newCmd = '{addr: {page_q, 1'b0, serAddr_d}, data: 8'h00, isRead: 1'b1};
        end
        else
        begin
          newCmd = '{addr: {page_q, 1'b0, serAddr_q}, data: byteOut_q, isRead: 1'b0};
        end
      end
    end
  end

  assign coreCmd = cmd_q;                                // request word leaves straight from its register

  // local page and port registers answer at once, others go to the core
  always_comb
  begin
    state_d  = state_q;
    cmd_d    = cmd_q;
    page_d   = page_q;
    ioOut_d  = ioOut_q;
    rdData_d = rdData_q;
    case (state_q)
      ST_IDLE:
      begin
        if (newReq)
        begin
          cmd_d   = newCmd;                              // see R4
          state_d = ST_DONE;
          if (newCmd.addr[7:0] != PAGE_REG_OFFS && newCmd.addr[7:0] != IO_REG_OFFS)
          begin
            state_d = ST_CORE;
          end
        end
      end
      ST_CORE:
      begin
        if (coreAck)
        begin
          rdData_d = cmd_q.isRead ? coreRdata : rdData_q;
          state_d  = ST_IDLE;
        end
      end
      ST_DONE:
      begin
        state_d = ST_IDLE;
        if (cmd_q.addr[7:0] == PAGE_REG_OFFS)
        begin
          page_d   = cmd_q.isRead ? page_q : cmd_q.data; // see R22
          rdData_d = page_q;
        end
        else
        begin
          ioOut_d  = cmd_q.isRead ? ioOut_q : cmd_q.data; // see R10
          rdData_d = portS;
        end
      end
      default:
      begin
        state_d = ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge ref_clk)
  begin
    if (!rst_n)
    begin
      state_q     <= ST_IDLE;
      cmd_q       <= '0;
      page_q      <= PAGE_RST;
      ioOut_q     <= IO_RST;
      rdData_q    <= 8'h00;
      addrLatch_q <= 8'h00;
      serAddr_q   <= 7'h00;
      serRead_q   <= 1'b0;
      adOe_q      <= 1'b0;
      coreReq     <= 1'b0;
    end
    else
    begin
      state_q     <= state_d;
      cmd_q       <= cmd_d;
      page_q      <= page_d;
      ioOut_q     <= ioOut_d;
      rdData_q    <= rdData_d;
      addrLatch_q <= addrLatch_d;
      serAddr_q   <= serAddr_d;
      serRead_q   <= serRead_d;
      adOe_q      <= adOe_d;
      coreReq     <= state_d == ST_CORE;
    end
  end

  // ************************************************************************
  // pins: ready, interrupts, port roles, power state
  // ************************************************************************
  logic [$clog2(CLKOUT_DIV)-1:0] divCnt_q, divCnt_d;
  logic       clkDiv_q, clkDiv_d;
  logic [7:0] portOut_d, portOe_d, txTrig_d;
  logic       ready_d, prim_d, sec_d;

  always_comb
  begin
    divCnt_d = divCnt_q + 1'b1;
    clkDiv_d = clkDiv_q;
    if (divCnt_q == $bits(divCnt_q)'(CLKOUT_DIV - 1))
    begin
      divCnt_d = '0;
      clkDiv_d = !clkDiv_q;
    end
    // ready drops with the request and rises once the engine is idle again
    ready_d = state_d == ST_IDLE && !newReq;             // see R8
    prim_d  = |(coreIrq & primaryIrqMask);               // see R9
    sec_d   = clkoutSel ? clkDiv_q : |(coreIrq & secondaryIrqMask);   // see R13
    portOut_d = rdData_d;
    portOe_d  = {8{adOe_d}};
    txTrig_d  = '0;
    if (selAS)
    begin
      for (int i = 0; i < 8; i++)
      begin
        case (pinRole[2*i +: 2])                         // see R14
          ROLE_MON:
          begin
            portOut_d[i] = canActivity[i % 2];
            portOe_d[i]  = 1'b1;
          end
          ROLE_IRQ:
          begin
            portOut_d[i] = coreIrq[i % IRQ_W];           // see R11
            portOe_d[i]  = 1'b1;
          end
          ROLE_GPIO:
          begin
            portOut_d[i] = ioOut_q[i];                   // see R10
            portOe_d[i]  = gpioDir[i];
            txTrig_d[i]  = serialMode && txTrigEn[i] && !gpioDir[i] && portS[i] && !portPrev[i];   // see R12
          end
          default:
          begin
            portOut_d[i] = 1'b0;
            portOe_d[i]  = 1'b0;
          end
        endcase
      end
    end
  end

  always_ff @(posedge ref_clk)
  begin
    if (!rst_n)
    begin
      divCnt_q          <= '0;
      clkDiv_q          <= 1'b0;
      readyOut          <= 1'b0;
      primaryIrqLine    <= 1'b0;
      clkoutOrIrqLine   <= 1'b0;
      portOut           <= 8'h00;
      portOe            <= 8'h00;
      txTrigger         <= 8'h00;
      sleepStateOut     <= 1'b0;
      powerDownStateOut <= 1'b0;
      eepromBootMode    <= 1'b0;
    end
    else
    begin
      divCnt_q          <= divCnt_d;
      clkDiv_q          <= clkDiv_d;
      readyOut          <= ready_d;
      primaryIrqLine    <= prim_d;
      clkoutOrIrqLine   <= sec_d;
      portOut           <= portOut_d;
      portOe            <= portOe_d;
      txTrigger         <= txTrig_d;
      sleepStateOut     <= coreSleep;                    // see R15
      powerDownStateOut <= corePowerDown;
      eepromBootMode    <= selAS && selBS;               // see R16
    end
  end

endmodule : chai_host_access

/* File: chai_host_access_chk.sv */
// pin-level checker of the host access front end
`timescale 1ns/10ps
module chai_host_access_chk
  import chai_pkg::*;
#(
  parameter int IRQ_W = 4
)
(
  input wire logic             ref_clk,
  input wire logic             rst_n,
  input wire logic             ifaceSelectA,
  input wire logic             ifaceSelectB,
  input wire logic             rdOrEnable,
  input wire logic             clkoutSel,
  input wire logic             coreSleep,
  input wire logic             corePowerDown,
  input wire logic [15:0]      pinRole,
  input wire logic [IRQ_W-1:0] coreIrq,
  input wire logic [IRQ_W-1:0] primaryIrqMask,
  input wire logic [IRQ_W-1:0] secondaryIrqMask,
  input wire logic [7:0]       portOut,
  input wire logic [7:0]       portOe,
  input wire logic [7:0]       txTrigger,
  input wire logic             primaryIrqLine,
  input wire logic             clkoutOrIrqLine,
  input wire logic             sleepStateOut,
  input wire logic             powerDownStateOut,
  input wire logic             eepromBootMode
);
  // ****************************************
  // assertions, all in the core clock domain
  // ****************************************
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_n);

  a_irq_primary_or: assert property ($past(rst_n, 2) |-> primaryIrqLine == |$past(coreIrq & primaryIrqMask))
    else $error("primary irq line wrong");
  a_irq_second_or: assert property (!clkoutSel && $past(!clkoutSel) && $past(rst_n, 2)
    |-> clkoutOrIrqLine == |$past(coreIrq & secondaryIrqMask))
    else $error("secondary irq line wrong");
  a_clkout_high_len: assert property (clkoutSel [*8] ##1 $rose(clkoutOrIrqLine)
    |-> clkoutOrIrqLine [*4] ##1 !clkoutOrIrqLine)
    else $error("clock output phase wrong");
  a_power_state_copy: assert property ($past(rst_n, 2)
    |-> sleepStateOut == $past(coreSleep) && powerDownStateOut == $past(corePowerDown))
    else $error("power state pins wrong");
  a_boot_flag: assert property ($stable({ifaceSelectA, ifaceSelectB}) [*5]
    |-> eepromBootMode == (ifaceSelectA && ifaceSelectB))
    else $error("boot flag wrong");
  // the bus is only turned round while the read strobe is held
  a_bus_quiet: assert property ((!ifaceSelectA && !ifaceSelectB && rdOrEnable) [*5] |-> portOe == 8'h00)
    else $error("parallel bus driven without read");
  a_no_trigger_par: assert property ((!ifaceSelectA) [*5] |-> txTrigger == 8'h00)
    else $error("trigger in parallel mode");
  a_comm_pin_input: assert property ((ifaceSelectA && pinRole[1:0] == ROLE_COMM) [*5] |-> !portOe[0])
    else $error("comm pin driven");
  a_irq_pin_mirror: assert property ((ifaceSelectA && pinRole[5:4] == ROLE_IRQ && $stable(coreIrq)) [*5]
    |-> portOe[2] && portOut[2] == coreIrq[2 % IRQ_W])
    else $error("irq pin wrong");
endmodule : chai_host_access_chk

bind chai_host_access chai_host_access_chk #(.IRQ_W(IRQ_W)) chai_host_access_chk_inst (
  .ref_clk(ref_clk), .rst_n(rst_n), .ifaceSelectA(ifaceSelectA), .ifaceSelectB(ifaceSelectB),
  .rdOrEnable(rdOrEnable), .clkoutSel(clkoutSel), .coreSleep(coreSleep), .corePowerDown(corePowerDown),
  .pinRole(pinRole), .coreIrq(coreIrq), .primaryIrqMask(primaryIrqMask), .secondaryIrqMask(secondaryIrqMask),
  .portOut(portOut), .portOe(portOe), .txTrigger(txTrigger), .primaryIrqLine(primaryIrqLine),
  .clkoutOrIrqLine(clkoutOrIrqLine), .sleepStateOut(sleepStateOut), .powerDownStateOut(powerDownStateOut),
  .eepromBootMode(eepromBootMode));

/* File: chai_host_model.sv */
// host cpu model: parallel bus master and serial master
`timescale 1ns/10ps
module chai_host_model
(
  input  wire logic       ref_clk,
  input  wire logic       strobeMode,
  input  wire logic       readyOut,
  input  wire logic [7:0] portOut,
  input  wire logic       deviceToHostData,
  output logic            csN,
  output logic            aleOrStrobe,
  output logic            wrOrRwN,
  output logic            rdOrEnable,
  output logic [7:0]      pins,
  output logic            serialClk,
  output logic            slaveSelectLineN,
  output logic            hostToDeviceData
);
  // ****************************
  // bus cycles of the host side
  // ****************************
  initial
  begin
    {csN, aleOrStrobe, wrOrRwN, rdOrEnable, pins} = 12'hB00;
    {serialClk, slaveSelectLineN, hostToDeviceData} = 3'h2;
  end

  // the host waits for ready at most 300 cycles, then goes on regardless
  task automatic wait_rdy(input logic v);
    for (int i = 0; i < 300 && readyOut !== v; i++)
      @(posedge ref_clk) #1;
  endtask : wait_rdy

  // one byte access: address latched first, then one strobe
  task automatic par_acc(input logic rd, input logic [7:0] a, input logic [7:0] d, output logic [7:0] q);
    @(posedge ref_clk) #1;
    wrOrRwN = !strobeMode || rd;
    rdOrEnable = !strobeMode;
    // strobes settle a cycle before select, so a change of bus style makes no false edge
    @(posedge ref_clk) #1 {csN, aleOrStrobe, pins} = {2'h1, a};
    repeat (3) @(posedge ref_clk);
    #1 aleOrStrobe = 1'b0;
    repeat (5) @(posedge ref_clk);
    #1 pins = rd ? ~a : d; // released pins show inverse of last value
    repeat (2) @(posedge ref_clk);
    #1;
    if (strobeMode)
      rdOrEnable = 1'b1;
    else if (rd)
      rdOrEnable = 1'b0;
    else
      wrOrRwN = 1'b0;
    if (!rd)
      repeat (3) @(posedge ref_clk) #1;
    if (!rd)
      {wrOrRwN, rdOrEnable} = {2{!strobeMode}}; // strobe style drops E while R/W still says write
    wait_rdy(1'b0);
    wait_rdy(1'b1);
    repeat (2) @(posedge ref_clk) #1;
    q = portOut;
    {wrOrRwN, rdOrEnable} = {1'b1, !strobeMode};
    repeat (3) @(posedge ref_clk);
    #1 csN = 1'b1;
  endtask : par_acc

  // serial byte, msb first; data set on rise, sampled on fall
  task automatic spi_byte(input logic [7:0] tx, output logic [7:0] rx);
    for (int i = 7; i >= 0; i--)
    begin
      {hostToDeviceData, serialClk} = {tx[i], 1'b1};
      #62.5 rx[i] = deviceToHostData;
      serialClk = 1'b0;
      #62.5;
    end
    hostToDeviceData = ~tx[0];
    repeat (6) @(posedge ref_clk) #1;
    wait_rdy(1'b1);
  endtask : spi_byte

  task automatic select(input logic v);
    @(posedge ref_clk) #1 slaveSelectLineN = v;
    repeat (4) @(posedge ref_clk) #1;
  endtask : select

  task automatic set_pins(input logic [7:0] v);
    @(posedge ref_clk) #1 pins = v;
  endtask : set_pins
endmodule : chai_host_model

/* File: tb_top.sv */
// self-checking testbench of the host access front end
`timescale 1ns/10ps
module tb_top;
  import chai_pkg::*;
  logic ref_clk = 0, rst_n = 0, ifaceSelectA = 0, ifaceSelectB = 0, incrementEn = 0, clkoutSel = 0;
  logic coreSleep = 0, corePowerDown = 0, coreAck = 0;
  logic [1:0] canActivity = 0;
  logic [3:0] coreIrq = 0, primaryIrqMask = 0, secondaryIrqMask = 0, ackCnt = 0;
  logic [7:0] gpioDir = 0, txTrigEn = 0, coreRdata = 0, hostPins, wirePins, portOut, portOe, txTrigger, q;
  logic [15:0] pinRole = 0;
  logic csN, aleOrStrobe, wrOrRwN, rdOrEnable, serialClk, slaveSelectLineN, hostToDeviceData, coreReq;
  logic deviceToHostData, readyOut, primaryIrqLine, clkoutOrIrqLine, sleepStateOut, powerDownStateOut, eepromBootMode;
  chai_req_type coreCmd;
  chai_req_type log_q[$];
  int num_errors = 0, checks = 0, cyc = 0;

  // shared pins: whoever enables drives
  assign wirePins = (portOut & portOe) | (hostPins & ~portOe);

  chai_host_access #(.IRQ_W(4)) chai_host_access_inst (
    .ref_clk(ref_clk), .rst_n(rst_n), .ifaceSelectA(ifaceSelectA), .ifaceSelectB(ifaceSelectB),
    .csN(csN), .aleOrStrobe(aleOrStrobe), .wrOrRwN(wrOrRwN), .rdOrEnable(rdOrEnable), .portIn(wirePins),
    .portOut(portOut), .portOe(portOe), .serialClk(serialClk), .slaveSelectLineN(slaveSelectLineN),
    .hostToDeviceData(hostToDeviceData), .deviceToHostData(deviceToHostData), .readyOut(readyOut),
    .primaryIrqLine(primaryIrqLine), .clkoutOrIrqLine(clkoutOrIrqLine), .sleepStateOut(sleepStateOut),
    .powerDownStateOut(powerDownStateOut), .eepromBootMode(eepromBootMode), .txTrigger(txTrigger),
    .incrementEn(incrementEn), .clkoutSel(clkoutSel), .primaryIrqMask(primaryIrqMask),
    .secondaryIrqMask(secondaryIrqMask), .pinRole(pinRole), .gpioDir(gpioDir), .txTrigEn(txTrigEn),
    .coreIrq(coreIrq), .canActivity(canActivity), .coreSleep(coreSleep), .corePowerDown(corePowerDown),
    .coreReq(coreReq), .coreCmd(coreCmd), .coreAck(coreAck), .coreRdata(coreRdata));

  chai_host_model chai_host_model_inst (
    .ref_clk(ref_clk), .strobeMode(ifaceSelectB), .readyOut(readyOut), .portOut(portOut),
    .deviceToHostData(deviceToHostData), .csN(csN), .aleOrStrobe(aleOrStrobe), .wrOrRwN(wrOrRwN),
    .rdOrEnable(rdOrEnable), .pins(hostPins), .serialClk(serialClk), .slaveSelectLineN(slaveSelectLineN),
    .hostToDeviceData(hostToDeviceData));

  // ****************************
  // clock, core stub and helpers
  // ****************************
  always #5 ref_clk = ~ref_clk;

  // core answers each request three cycles after it rises; data is address xor A5
  always @(posedge ref_clk)
  begin
    #1 coreAck = 1'b0;
    if (ackCnt == 4'h3)
    begin
      coreAck = 1'b1;
      coreRdata = coreCmd.addr[7:0] ^ 8'hA5;
      ackCnt = 4'h0;
      log_q.push_back(coreCmd);
    end
    else if (ackCnt != 4'h0)
      ackCnt++;
    else if (coreReq === 1'b1)
      ackCnt = 4'h1;
    cyc++;
    if (cyc == 20000)
    begin
      num_errors++;
      end_sim();
    end
  end

  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    checks++;
    if (seen !== exp)
    begin
      num_errors++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : chk

  function automatic logic seen_cmd(input logic [15:0] a, input logic rd, input logic [7:0] d);
    seen_cmd = 1'b0;
    foreach (log_q[i])
      if (log_q[i].addr === a && log_q[i].isRead === rd && (rd || log_q[i].data === d))
        seen_cmd = 1'b1;
  endfunction : seen_cmd

  task automatic end_sim();
    if (num_errors == 0 && checks > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask : end_sim

  // ****************************
  // scenarios
  // ****************************
  task automatic t_irq();
    int r = 0, t1 = 0;
    logic pv = 1'b1;
    primaryIrqMask = 4'h5;
    secondaryIrqMask = 4'hA;
    for (int i = 0; i < 16; i++)
    begin
      coreIrq = 4'(i);
      repeat (3) @(posedge ref_clk) #1;
      chk(primaryIrqLine, |(coreIrq & 4'h5));
      chk(clkoutOrIrqLine, |(coreIrq & 4'hA));
    end
    {coreIrq, clkoutSel} = 5'h01;
    for (int k = 0; k < 60 && r < 2; k++)
    begin
      @(posedge ref_clk) #1;
      if (clkoutOrIrqLine === 1'b1 && pv === 1'b0)
      begin
        if (r == 1)
          chk(16'(k - t1), 16'(2 * CLKOUT_DIV));
        {t1, r} = {k, r + 1};
      end
      pv = clkoutOrIrqLine;
    end
    chk(16'(r), 16'h2);
    repeat (5) @(posedge ref_clk) #1;
    clkoutSel = 1'b0;
  endtask : t_irq

  task automatic t_power();
    for (int i = 0; i < 4; i++)
    begin
      coreSleep = i[0];
      corePowerDown = i[1];
      repeat (2) @(posedge ref_clk) #1;
      chk({powerDownStateOut, sleepStateOut}, 16'(i));
    end
  endtask : t_power

  // both bus styles; the page written first must prefix every remote address
  task automatic t_parallel();
    logic [7:0] pg;
    for (int b = 0; b < 2; b++)
    begin
      ifaceSelectB = b[0];
      pg = 8'h12 + 8'(b);
      repeat (6) @(posedge ref_clk) #1;
      chai_host_model_inst.par_acc(1'b0, 8'h7F, pg, q);
      chai_host_model_inst.par_acc(1'b1, 8'h7F, 8'h00, q);
      chk(q, pg);
      chai_host_model_inst.par_acc(1'b1, 8'hC3, 8'h00, q);
      chk(q, 8'hC3 ^ 8'hA5);
      chk(seen_cmd({pg, 8'hC3}, 1'b1, 8'h00), 16'h1);
      chai_host_model_inst.par_acc(1'b0, 8'h40, 8'h5A, q);
      chk(seen_cmd({pg, 8'h40}, 1'b0, 8'h5A), 16'h1);
    end
  endtask : t_parallel

  task automatic t_serial();
    int n = log_q.size();
    ifaceSelectA = 1'b1;
    ifaceSelectB = 1'b0;
    repeat (6) @(posedge ref_clk) #1;
    chai_host_model_inst.spi_byte(8'h85, q);
    chk(16'(log_q.size()), 16'(n));
    chai_host_model_inst.select(1'b0);
    chai_host_model_inst.spi_byte(8'h85, q);
    chai_host_model_inst.spi_byte(8'h00, q);
    chai_host_model_inst.select(1'b1);
    chk(q, 8'h05 ^ 8'hA5);
    chk(seen_cmd(16'h1305, 1'b1, 8'h00), 16'h1);
    incrementEn = 1'b1;
    chai_host_model_inst.select(1'b0);
    chai_host_model_inst.spi_byte(8'h30, q);
    chai_host_model_inst.spi_byte(8'h11, q);
    chai_host_model_inst.spi_byte(8'h22, q);
    chai_host_model_inst.select(1'b1);
    chk(seen_cmd(16'h1330, 1'b0, 8'h11), 16'h1);
    chk(seen_cmd(16'h1331, 1'b0, 8'h22), 16'h1);
  endtask : t_serial

  // pin roles comm, monitor, irq, gpio; trigger on a rising input pin
  task automatic t_port();
    int n = 0;
    pinRole = 16'hFFE4;
    gpioDir = 8'h0F;
    txTrigEn = 8'h10;
    canActivity = 2'h2;
    coreIrq = 4'h4;
    chai_host_model_inst.set_pins(8'h00);
    repeat (6) @(posedge ref_clk) #1;
    chk(portOe, 8'h0E);
    chk(portOut[2:1], 2'h3);
    chai_host_model_inst.set_pins(8'h10);
    repeat (10) @(posedge ref_clk) #1 n += int'(txTrigger === 8'h10);
    chk(16'(n), 16'h1);
    chai_host_model_inst.select(1'b0);
    chai_host_model_inst.spi_byte(8'h7E, q);
    chai_host_model_inst.spi_byte(8'h08, q);
    chai_host_model_inst.select(1'b1);
    repeat (4) @(posedge ref_clk) #1;
    chk(portOut[3], 1'b1);
    chai_host_model_inst.select(1'b0);
    chai_host_model_inst.spi_byte(8'hFE, q);
    chai_host_model_inst.spi_byte(8'h00, q);
    chai_host_model_inst.select(1'b1);
    chk(q, 8'h1E);
    ifaceSelectB = 1'b1;
    repeat (6) @(posedge ref_clk) #1;
    chk(eepromBootMode, 1'b1);
  endtask : t_port

  initial
  begin
    repeat (20) @(posedge ref_clk);
    #1 rst_n = 1'b1;
    repeat (10) @(posedge ref_clk) #1;
    t_irq();
    t_power();
    t_parallel();
    t_serial();
    t_port();
    end_sim();
  end
endmodule : tb_top
